// file: rtl/fmwp_regs.svh
/*
 * Constants of the field memory write port: pointer limits, block
 * geometry, entry sequence edge numbers and hold counts.
 * Assumes inclusion by the package only, with the guard below.
 */
// Functional notes
// - Filter pin low: data bypasses the noise path, plain field memory.
// - Filter on: random block access is refused on both ports.
// - First write edge after clear rises loads pointer to minus twelve.
// - Clear may arrive unsynchronised while advance enable is low.
// - Clear high 1024 edges with advance high enters test mode.
// - Block entry: edges 1-2 commit low advance high, 3-4 reversed.
// - Edge five: advance picks address source, data bit zero or commit.
// - Filter on: bits 11-4 luma, 3-2 U odd/even, 1-0 V odd/even.
// - Filter on: output word uses the same luma and chroma layout.
// - Noise path settings come only from the serial setup, never pins; here the filter is switched by the i_noise_filter_on pin.
// - Eighteen latency edges follow before writing at the new block.
// - Each edge with advance high, except the clear edge and edges in address or latency phase, latches the word and steps pointer.
// - Commit low at the previous edge masks the store; array kept.
`ifndef FMWP_REGS_SVH
`define FMWP_REGS_SVH

`define FMWP_WORD_W        12
`define FMWP_PTR_W         19
`define FMWP_BLK_W         13
`define FMWP_EDGE_W        5
`define FMWP_PTR_RESET     19'h7FFF4
`define FMWP_ARRAY_LAST    19'h3BFFF
`define FMWP_BLOCK_WORDS   19'h00028
`define FMWP_BLOCK_MAX     13'h17FF
`define FMWP_ENTRY_SWAP    5'h03
`define FMWP_ENTRY_LAST    5'h04
`define FMWP_ADDR_FIRST    5'h05
`define FMWP_ADDR_LAST     5'h11
`define FMWP_LATENCY       5'h12
`define FMWP_TEST_HOLD     32'h00000400
`define FMWP_MIN_RUN       32'h00000028
`define FMWP_FIFO_DEPTH    32'h00000010

`endif

// file: rtl/fmwp_pkg.sv
/*
 * Types shared by the write port modules.
 * Assumes fmwp_regs.svh is on the include path.
 */
`include "fmwp_regs.svh"

package fmwp_pkg;
	typedef logic signed [`FMWP_PTR_W-1:0] fmwp_ptr_t;
	typedef logic [`FMWP_BLK_W-1:0]        fmwp_blk_t;
	typedef logic [`FMWP_EDGE_W-1:0]       fmwp_edge_t;
	// packed order reproduces the pin layout of the filtered word
	typedef struct packed {
		logic [7:0] luma;
		logic [1:0] chroma_u;
		logic [1:0] chroma_v;
	} fmwp_yuv_t;
	typedef enum logic [1:0] {
		FMWP_ST_IDLE,
		FMWP_ST_ENTRY,
		FMWP_ST_ADDR,
		FMWP_ST_LAT
	} fmwp_state_t;
endpackage

// file: rtl/fmwp_stream_if.sv
/*
 * Valid/ready word stream between the write port modules.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps

interface fmwp_stream_if #(
	parameter int WIDTH = 31
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// file: rtl/fmwp_sync.sv
/*
 * Two-stage synchroniser for a bundle of pin levels.
 * Assumes each bit is a level; multi-bit words must be stable when used.
 */
`timescale 1ns/100ps

module fmwp_sync #(
	parameter int WIDTH = 17
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_b,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// file: rtl/fmwp_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two.
 */
`timescale 1ns/100ps

module fmwp_fifo #(
	parameter int WIDTH = 31,
	parameter int DEPTH = 16
) (
	input  wire logic   i_clock,
	input  wire logic   i_rst_b,
	fmwp_stream_if.snk  i_push,
	fmwp_stream_if.src  o_pop
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW:0]      wp_q;
	logic [AW:0]      wp_d;
	logic [AW:0]      rp_q;
	logic [AW:0]      rp_d;
	logic             full;
	logic             empty;

	assign full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign empty = (wp_q == rp_q);
	assign i_push.ready = !full;
	assign o_pop.valid  = !empty;
	assign o_pop.data   = mem_q[rp_q[AW-1:0]];

	always_comb begin
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		if (i_push.valid && !full) begin
			mem_d[wp_q[AW-1:0]] = i_push.data;
			wp_d = wp_q + 1'b1;
		end
		if (o_pop.ready && !empty) begin
			rp_d = rp_q + 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wp_q <= '0;
			rp_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			mem_q <= mem_d;
		end
	end
endmodule

// file: rtl/fmwp_top.sv
/*
 * Write port of a serial field memory: pointer clear, advance and
 * commit gating, random block entry, filter data path, array queue.
 * Assumes the write pins are asynchronous to i_clock and that the write
 * clock runs well below half of i_clock.
 */
`timescale 1ns/100ps

module fmwp_top
	import fmwp_pkg::*;
#(
	parameter int FIFO_DEPTH = `FMWP_FIFO_DEPTH,
	parameter int TEST_HOLD  = `FMWP_TEST_HOLD
) (
	input  wire logic                    i_clock,
	input  wire logic                    i_rst_b,
	input  wire logic                    i_wr_clock,
	input  wire logic                    i_wr_pointer_clear,
	input  wire logic                    i_wr_advance_enable,
	input  wire logic                    i_wr_commit_enable,
	input  wire logic [`FMWP_WORD_W-1:0] i_data_in,
	input  wire logic                    i_noise_filter_on,
	input  wire logic                    i_mem_ready,
	output logic                         o_mem_valid,
	output logic      [`FMWP_PTR_W-1:0]  o_mem_addr,
	output logic      [`FMWP_WORD_W-1:0] o_mem_data,
	output logic                         o_nr_valid,
	output logic      [`FMWP_WORD_W-1:0] o_nr_word,
	output logic                         o_block_mode,
	output logic                         o_test_mode,
	output logic                         o_queue_full,
	output logic                         o_word_dropped
);
	localparam int SYNC_W = `FMWP_WORD_W + 5;
	localparam int Q_W    = `FMWP_PTR_W + `FMWP_WORD_W;
	localparam int HOLD_W = $clog2(TEST_HOLD + 1);

	logic [SYNC_W-1:0]       pins_s;
	logic                    wck_s;
	logic                    clr_s;
	logic                    we_s;
	logic                    ie_s;
	logic                    nr_s;
	logic [`FMWP_WORD_W-1:0] din_s;

	fmwp_sync #(.WIDTH(SYNC_W)) u_sync (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_async ({i_wr_clock, i_wr_pointer_clear, i_wr_advance_enable,
		           i_wr_commit_enable, i_noise_filter_on, i_data_in}),
		.o_sync  (pins_s)
	);
	assign {wck_s, clr_s, we_s, ie_s, nr_s, din_s} = pins_s;

	fmwp_stream_if #(.WIDTH(Q_W)) push_if ();
	fmwp_stream_if #(.WIDTH(Q_W)) pop_if ();

	fmwp_fifo #(.WIDTH(Q_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_push  (push_if),
		.o_pop   (pop_if)
	);

	logic                    wck_prev_q, wck_prev_d;
	logic                    clr_prev_q, clr_prev_d;
	logic                    arm_q, arm_d;
	fmwp_ptr_t               ptr_q, ptr_d;
	logic                    ie_prev_q, ie_prev_d;
	logic                    pend_q, pend_d;
	logic [Q_W-1:0]          pend_word_q, pend_word_d;
	fmwp_state_t             st_q, st_d;
	fmwp_edge_t              edge_q, edge_d;
	logic                    entry_ok_q, entry_ok_d;
	logic                    sel_ie_q, sel_ie_d;
	fmwp_blk_t               blk_q, blk_d;
	logic [HOLD_W-1:0]       hold_q, hold_d;
	logic                    test_q, test_d;
	logic                    nr_valid_q, nr_valid_d;
	fmwp_yuv_t               nr_word_q, nr_word_d;
	logic                    drop_q, drop_d;
	logic                    full_q, full_d;
	logic                    out_valid_q, out_valid_d;
	logic [Q_W-1:0]          out_word_q, out_word_d;
	logic                    blk_mode_q, blk_mode_d;
	logic                    wr_edge;
	logic                    clr_rise;
	logic                    writes_on;
	logic                    take;
	fmwp_edge_t              nxt_edge;
	logic                    addr_bit;

	assign wr_edge   = wck_s && !wck_prev_q;
	assign clr_rise  = clr_s && !clr_prev_q;
	// address shift and latency own the pins, so normal writes pause
	assign writes_on = (st_q == FMWP_ST_IDLE) || (st_q == FMWP_ST_ENTRY);
	assign take      = wr_edge && !arm_q && writes_on && we_s;
	assign nxt_edge  = edge_q + 1'b1;
	assign addr_bit  = sel_ie_q ? ie_s : din_s[0];

	assign push_if.valid = pend_q;
	assign push_if.data  = pend_word_q;
	assign pop_if.ready  = !out_valid_q || i_mem_ready;

	always_comb begin
		wck_prev_d  = wck_s;
		clr_prev_d  = clr_s;
		arm_d       = arm_q;
		ptr_d       = ptr_q;
		ie_prev_d   = ie_prev_q;
		pend_d      = pend_q;
		pend_word_d = pend_word_q;
		st_d        = st_q;
		edge_d      = edge_q;
		entry_ok_d  = entry_ok_q;
		sel_ie_d    = sel_ie_q;
		blk_d       = blk_q;
		hold_d      = hold_q;
		test_d      = test_q;
		nr_valid_d  = 1'b0;
		nr_word_d   = nr_word_q;
		drop_d      = drop_q;
		full_d      = !push_if.ready;
		out_valid_d = out_valid_q;
		out_word_d  = out_word_q;

		if (pend_q && push_if.ready) begin
			pend_d = 1'b0;
		end
		if (wr_edge) begin
			ie_prev_d = ie_s;
			if (clr_s && we_s) begin
				if (hold_q == HOLD_W'(TEST_HOLD - 1)) begin
					test_d = 1'b1;
				end else begin
					hold_d = hold_q + 1'b1;
				end
			end else begin
				hold_d = '0;
			end
		end

		if (wr_edge && arm_q) begin
			// a clear also ends any run; queued words still drain
			ptr_d      = `FMWP_PTR_RESET;
			arm_d      = 1'b0;
			edge_d     = '0;
			entry_ok_d = 1'b1;
			blk_d      = '0;
			st_d       = nr_s ? FMWP_ST_IDLE : FMWP_ST_ENTRY;
		end else if (wr_edge) begin
			unique case (st_q)
				FMWP_ST_IDLE: begin
				end
				FMWP_ST_ENTRY: begin
					edge_d = nxt_edge;
					if (nxt_edge < `FMWP_ENTRY_SWAP) begin
						entry_ok_d = entry_ok_q && !ie_s && we_s;
					end else begin
						entry_ok_d = entry_ok_q && ie_s && !we_s;
					end
					if (nxt_edge == `FMWP_ENTRY_LAST) begin
						st_d = (entry_ok_q && ie_s && !we_s)
							? FMWP_ST_ADDR : FMWP_ST_IDLE;
					end
				end
				FMWP_ST_ADDR: begin
					edge_d = nxt_edge;
					if (nxt_edge == `FMWP_ADDR_FIRST) begin
						sel_ie_d = we_s;
						blk_d = {blk_q[`FMWP_BLK_W-2:0],
							we_s ? ie_s : din_s[0]};
					end else begin
						blk_d = {blk_q[`FMWP_BLK_W-2:0], addr_bit};
					end
					if (nxt_edge == `FMWP_ADDR_LAST) begin
						st_d   = FMWP_ST_LAT;
						edge_d = '0;
					end
				end
				FMWP_ST_LAT: begin
					edge_d = nxt_edge;
					if (nxt_edge == `FMWP_LATENCY) begin
						st_d = FMWP_ST_IDLE;
						// an out-of-range block leaves the pointer alone
						if (blk_q <= `FMWP_BLOCK_MAX) begin
							ptr_d = fmwp_ptr_t'({6'h00, blk_q}
								* `FMWP_BLOCK_WORDS);
						end
					end
				end
			endcase
		end

		if (take) begin
			ptr_d = (ptr_q == `FMWP_ARRAY_LAST) ? '0 : ptr_q + 1'b1;
			if (ie_prev_q) begin
				if (pend_q && !push_if.ready) begin
					drop_d = 1'b1;
				end
				pend_d      = 1'b1;
				pend_word_d = {ptr_q, din_s};
			end
			if (nr_s) begin
				nr_valid_d = 1'b1;
				nr_word_d  = fmwp_yuv_t'(din_s);
			end
		end

		// a new clear rise wins over the consuming edge; may be async
		if (clr_rise) begin
			arm_d = 1'b1;
		end

		if (pop_if.valid && pop_if.ready) begin
			out_valid_d = 1'b1;
			out_word_d  = pop_if.data;
		end else if (i_mem_ready) begin
			out_valid_d = 1'b0;
		end
		blk_mode_d = (st_d != FMWP_ST_IDLE);
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wck_prev_q  <= 1'b0;
			clr_prev_q  <= 1'b0;
			arm_q       <= 1'b0;
			ptr_q       <= `FMWP_PTR_RESET;
			ie_prev_q   <= 1'b0;
			pend_q      <= 1'b0;
			pend_word_q <= '0;
			st_q        <= FMWP_ST_IDLE;
			edge_q      <= '0;
			entry_ok_q  <= 1'b0;
			sel_ie_q    <= 1'b0;
			blk_q       <= '0;
			hold_q      <= '0;
			test_q      <= 1'b0;
			nr_valid_q  <= 1'b0;
			nr_word_q   <= '0;
			drop_q      <= 1'b0;
			full_q      <= 1'b0;
			out_valid_q <= 1'b0;
			out_word_q  <= '0;
			blk_mode_q  <= 1'b0;
		end else begin
			wck_prev_q  <= wck_prev_d;
			clr_prev_q  <= clr_prev_d;
			arm_q       <= arm_d;
			ptr_q       <= ptr_d;
			ie_prev_q   <= ie_prev_d;
			pend_q      <= pend_d;
			pend_word_q <= pend_word_d;
			st_q        <= st_d;
			edge_q      <= edge_d;
			entry_ok_q  <= entry_ok_d;
			sel_ie_q    <= sel_ie_d;
			blk_q       <= blk_d;
			hold_q      <= hold_d;
			test_q      <= test_d;
			nr_valid_q  <= nr_valid_d;
			nr_word_q   <= nr_word_d;
			drop_q      <= drop_d;
			full_q      <= full_d;
			out_valid_q <= out_valid_d;
			out_word_q  <= out_word_d;
			blk_mode_q  <= blk_mode_d;
		end
	end

	assign o_mem_valid    = out_valid_q;
	assign o_mem_addr     = out_word_q[Q_W-1:`FMWP_WORD_W];
	assign o_mem_data     = out_word_q[`FMWP_WORD_W-1:0];
	assign o_nr_valid     = nr_valid_q;
	assign o_nr_word      = nr_word_q;
	assign o_block_mode   = blk_mode_q;
	assign o_test_mode    = test_q;
	assign o_queue_full   = full_q;
	assign o_word_dropped = drop_q;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_entry_done;
		wr_edge && !arm_q && st_q == FMWP_ST_ENTRY
			&& nxt_edge == `FMWP_ENTRY_LAST;
	endsequence

	sequence s_entry_good;
		s_entry_done ##0 (entry_ok_q && ie_s && !we_s);
	endsequence

	a_ptr_clear_load: assert property (
		wr_edge && arm_q |=> ptr_q == `FMWP_PTR_RESET)
		else $error("pointer not at -12 after clear edge");
	a_ptr_advance: assert property (
		take && ptr_q != `FMWP_ARRAY_LAST
		|=> ptr_q == $past(ptr_q) + 1'b1)
		else $error("pointer did not step on advance edge");
	a_commit_mask: assert property (
		take && !ie_prev_q && !pend_q |=> !pend_q)
		else $error("masked word was queued");
	a_bypass_path: assert property (
		!nr_s |=> !o_nr_valid)
		else $error("filter path active with filter off");
	a_no_block_nr: assert property (
		wr_edge && arm_q && nr_s |=> st_q == FMWP_ST_IDLE)
		else $error("block entry begun with filter on");
	a_entry_seq: assert property (
		s_entry_good |=> st_q == FMWP_ST_ADDR)
		else $error("block address phase not entered");
	a_addr_select: assert property (
		wr_edge && !arm_q && st_q == FMWP_ST_ADDR
		&& nxt_edge == `FMWP_ADDR_FIRST |=> sel_ie_q == $past(we_s))
		else $error("address source not chosen at edge five");
	a_addr_length: assert property (
		st_q == FMWP_ST_ADDR |-> edge_q >= `FMWP_ENTRY_LAST
		&& edge_q < `FMWP_ADDR_LAST)
		else $error("address phase edge count out of range");
	a_latency_load: assert property (
		wr_edge && !arm_q && st_q == FMWP_ST_LAT
		&& nxt_edge == `FMWP_LATENCY && blk_q <= `FMWP_BLOCK_MAX
		|=> ptr_q == fmwp_ptr_t'({6'h00, $past(blk_q)} * `FMWP_BLOCK_WORDS)
		&& st_q == FMWP_ST_IDLE)
		else $error("block start not loaded after latency");
	a_bad_block: assert property (
		wr_edge && !arm_q && st_q == FMWP_ST_LAT
		&& nxt_edge == `FMWP_LATENCY && blk_q > `FMWP_BLOCK_MAX
		|=> $stable(ptr_q))
		else $error("invalid block moved the pointer");
	a_clear_arm: assert property (
		clr_rise |=> arm_q)
		else $error("clear rise not armed");
	a_test_entry: assert property (
		wr_edge && clr_s && we_s && hold_q == HOLD_W'(TEST_HOLD - 1)
		|=> o_test_mode)
		else $error("test mode not entered after hold");
	a_yuv_layout: assert property (
		take && nr_s |=> o_nr_valid && o_nr_word == $past(din_s))
		else $error("filter word layout wrong");
endmodule

// file: verification/fmwp_source.sv
/*
 * Model of the video source that drives the write pins.
 * Assumes the bench calls wr_edge once per write clock period and
 * that i_clock runs at 100 ns, giving an 800 ns write clock.
 */
`timescale 1ns/100ps

module fmwp_source (
	input  wire logic        i_clock,
	output logic             o_wr_clock,
	output logic             o_wr_pointer_clear,
	output logic             o_wr_advance_enable,
	output logic             o_wr_commit_enable,
	output logic      [11:0] o_data_in,
	output logic             o_noise_filter_on
);
	initial begin
		o_wr_clock = 1'b0;
		o_wr_pointer_clear = 1'b0;
		o_wr_advance_enable = 1'b0;
		o_wr_commit_enable = 1'b0;
		o_data_in = 12'h000;
		o_noise_filter_on = 1'b0;
	end

	// filter pin is only moved between frames, write clock idle
	task automatic set_filter(input logic on);
		@(posedge i_clock);
		o_noise_filter_on <= on;
	endtask

	// one write clock period: pins set while low, 4 low then 4 high
	task automatic wr_edge(input logic clr, input logic adv,
		input logic com, input logic [11:0] d);
		@(posedge i_clock);
		o_wr_pointer_clear <= clr;
		o_wr_advance_enable <= adv;
		o_wr_commit_enable <= com;
		o_data_in <= d;
		repeat (3) @(posedge i_clock);
		o_wr_clock <= 1'b1;
		repeat (4) @(posedge i_clock);
		o_wr_clock <= 1'b0;
		// hold time over: data no longer shows the last word
		o_data_in <= ~d;
	endtask
endmodule

// file: verification/fmwp_top_test.sv
/*
 * Self-checking bench of the write port: stream, mask, queue stall,
 * block entry, filter path and test mode.
 * Assumes fmwp_source drives all write pins; the bench is the array.
 */
`timescale 1ns/100ps

module fmwp_top_test;
	import fmwp_pkg::*;
	logic              i_clock;
	logic              i_rst_b;
	logic              mem_ready;
	logic              wc, clr, adv, com, nf;
	logic [11:0]       din;
	logic              mem_valid, nr_valid, blk_mode, test_mode;
	logic              q_full, dropped;
	logic [18:0]       mem_addr;
	logic [11:0]       mem_data, nr_word;
	int                bad_count = 0;
	int                comparisons = 0;
	int                nr_cnt = 0;
	logic [30:0]       got[$];
	logic [30:0]       exp_q[$];
	fmwp_ptr_t         ptr_m = -19'sd12;
	logic              clr_m = 1'b0;
	logic              com_m = 1'b0;
	logic              freeze = 1'b0;

	fmwp_source src (.i_clock(i_clock), .o_wr_clock(wc),
		.o_wr_pointer_clear(clr), .o_wr_advance_enable(adv),
		.o_wr_commit_enable(com), .o_data_in(din),
		.o_noise_filter_on(nf));

	fmwp_top #(.FIFO_DEPTH(16), .TEST_HOLD(8)) dut (
		.i_clock(i_clock), .i_rst_b(i_rst_b), .i_wr_clock(wc),
		.i_wr_pointer_clear(clr), .i_wr_advance_enable(adv),
		.i_wr_commit_enable(com), .i_data_in(din),
		.i_noise_filter_on(nf), .i_mem_ready(mem_ready),
		.o_mem_valid(mem_valid), .o_mem_addr(mem_addr),
		.o_mem_data(mem_data), .o_nr_valid(nr_valid),
		.o_nr_word(nr_word), .o_block_mode(blk_mode),
		.o_test_mode(test_mode), .o_queue_full(q_full),
		.o_word_dropped(dropped));

	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end

	always @(posedge i_clock) begin
		if (mem_valid === 1'b1 && mem_ready === 1'b1)
			got.push_back({mem_addr, mem_data});
		if (nr_valid === 1'b1)
			nr_cnt <= nr_cnt + 1;
	end

	task automatic check(input string n, input logic [30:0] s,
		input logic [30:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// one write edge plus the expected array traffic it causes
	task automatic wr(input logic c, input logic a, input logic m,
		input logic [11:0] d);
		src.wr_edge(c, a, m, d);
		if (c && !clr_m)
			ptr_m = -19'sd12;
		else if (a && !freeze) begin
			if (com_m)
				exp_q.push_back({ptr_m, d});
			ptr_m = ptr_m + 19'sd1;
		end
		clr_m = c;
		com_m = m;
		@(negedge i_clock);
	endtask

	task automatic check_q();
		// closing clear ends the run; the queued words then drain into the array
		wr(1'b1, 1'b0, 1'b0, 12'h000);
		wr(1'b0, 1'b0, 1'b0, 12'h000);
		repeat (40) @(negedge i_clock);
		check("word count", 31'(got.size()), 31'(exp_q.size()));
		for (int i = 0; i < exp_q.size() && i < got.size(); i++)
			check("array word", got[i], exp_q[i]);
		got.delete();
		exp_q.delete();
	endtask

	task automatic t_stream();
		@(posedge i_clock);
		mem_ready <= 1'b0;
		wr(1'b1, 1'b1, 1'b1, 12'h5A5);
		for (int i = 0; i < 44; i++) begin
			wr(1'b0, i != 20, i != 30, 12'h100 + 12'(i));
			if (i == 17) begin
				check("queue full", 31'(q_full), 31'h1);
				@(posedge i_clock);
				mem_ready <= 1'b1;
			end
		end
		check_q();
		check("dropped", 31'(dropped), 31'h0);
		check("bypass pulses", 31'(nr_cnt), 31'h0);
	endtask

	task automatic t_block(input logic [12:0] blk, input logic on_ie);
		wr(1'b1, 1'b1, 1'b1, 12'h000);
		wr(1'b0, 1'b1, 1'b0, 12'hB01);
		wr(1'b0, 1'b1, 1'b0, 12'hB02);
		freeze = 1'b1;
		wr(1'b0, 1'b0, 1'b1, 12'h000);
		wr(1'b0, 1'b0, 1'b1, 12'h000);
		check("entry mode", 31'(blk_mode), 31'h1);
		// address msb first; advance high at edge five picks the commit pin
		for (int b = 12; b >= 0; b--)
			wr(1'b0, on_ie && b == 12, on_ie && blk[b],
				{11'h000, !on_ie && blk[b]});
		for (int i = 1; i <= 18; i++) begin
			if (i == 18)
				check("latency mode", 31'(blk_mode), 31'h1);
			wr(1'b0, 1'b0, i == 18, 12'h000);
		end
		check("block done", 31'(blk_mode), 31'h0);
		freeze = 1'b0;
		// a block past the last one leaves the pointer where entry left it
		if (blk <= 13'h17FF)
			ptr_m = fmwp_ptr_t'(blk) * 19'sd40;
		for (int i = 0; i < 40; i++)
			wr(1'b0, 1'b1, 1'b1, 12'hC00 + 12'(i));
		check_q();
	endtask

	task automatic t_filter();
		logic [11:0] d;
		fmwp_yuv_t   y;
		src.set_filter(1'b1);
		wr(1'b1, 1'b1, 1'b1, 12'h000);
		wr(1'b0, 1'b1, 1'b0, 12'h001);
		wr(1'b0, 1'b1, 1'b0, 12'h002);
		wr(1'b0, 1'b0, 1'b1, 12'h000);
		wr(1'b0, 1'b0, 1'b1, 12'h000);
		check("filter entry", 31'(blk_mode), 31'h0);
		for (int i = 0; i < 40; i++) begin
			d = 12'h3C5 ^ 12'(i * 97);
			wr(1'b0, 1'b1, 1'b1, d);
			y = fmwp_yuv_t'(nr_word);
			check("filter word", 31'(nr_word), 31'(d));
			check("luma", 31'(y.luma), 31'(d[11:4]));
			check("chroma", 31'({y.chroma_u, y.chroma_v}), 31'(d[3:0]));
		end
		check("filter pulses", 31'(nr_cnt), 31'h2A);
		check_q();
		src.set_filter(1'b0);
	endtask

	task automatic t_test();
		for (int i = 0; i < 12; i++) begin
			wr(1'b1, 1'b1, 1'b1, 12'h000);
			if (i == 4)
				check("test early", 31'(test_mode), 31'h0);
		end
		check("test mode", 31'(test_mode), 31'h1);
	endtask

	initial begin
		i_rst_b = 1'b0;
		mem_ready = 1'b1;
		repeat (20) @(posedge i_clock);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_clock);
		t_stream();
		t_block(13'h0A05, 1'b0);
		t_block(13'h1234, 1'b1);
		t_block(13'h1800, 1'b0);
		t_filter();
		t_test();
		give_verdict();
	end

	// all scenarios take about 3000 cycles
	initial begin
		repeat (8000) @(posedge i_clock);
		bad_count++;
		give_verdict();
	end
endmodule
